// file: hw/tmr_pwm.sv
// Purpose: 16-bit timer with split counting methods and two PWM outputs.
// Assumes: tick_clock arrives as a one-cycle pulse synchronous to ref_clk.
// Notes:   Registers over AHB-Lite; every transfer takes one wait state.
`default_nettype none
module tmr_pwm
  import tmr_pwm_pkg::*;
#(
  parameter int PAIRS = 8
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Counting sources
  input  wire logic                 tick_clock,
  input  wire logic                 comparator_output,
  input  wire logic                 amplifier_digital_output,
  input  wire logic                 capture_input_level,
  // Pins and interrupt request
  output logic      [2*PAIRS-1:0]   pwm_pin_out,
  output logic      [2*PAIRS-1:0]   pwm_pin_oe,
  output logic                      timer_irq
);
  if (PAIRS < 1 || PAIRS > 8) begin : g_bad_pairs
    $error("PAIRS must lie between 1 and 8.");
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] ctrl;
  logic [15:0] period_limit;
  logic [31:0] cmp;
  logic [15:0] counter_value;
  logic        count_down;
  logic        timer_overflow_flag;
  logic        timer_irq_enable;
  logic        global_irq_enable;
  logic [4:0]  pin_ctrl;
  logic        clear_pulse;
  logic        dp_active;
  logic        dp_write;
  logic [31:0] dp_addr;

  // ****************************************
  // Field decode
  // ****************************************
  wire [1:0]  count_trigger_select = ctrl[POS_TRIG+:2];
  wire [1:0]  count_method         = ctrl[POS_METHOD+:2];
  wire        counter_enable       = ctrl[POS_CNT_EN];
  wire [2:0]  out0_mode_sel        = ctrl[POS_MODE0+:3];
  wire [2:0]  out1_mode_sel        = ctrl[POS_MODE1+:3];
  wire        out0_polarity        = ctrl[POS_POL0];
  wire        out1_polarity        = ctrl[POS_POL1];
  wire [15:0] compare_one          = cmp[15:0];
  wire [15:0] compare_two          = cmp[31:16];
  wire        out0_pin_enable      = pin_ctrl[POS_PEN0];
  wire        out1_pin_enable      = pin_ctrl[POS_PEN1];
  wire [2:0]  pin_pair_select      = pin_ctrl[POS_PAIR+:3];

  // ****************************************
  // Counter
  // ****************************************
  wire trig_ok =
    (count_trigger_select == 2'b00) ? 1'b1 :
    (count_trigger_select == 2'b01) ? comparator_output :
    (count_trigger_select == 2'b10) ? amplifier_digital_output :
    capture_input_level;
  wire        step    = counter_enable & tick_clock & trig_ok;
  wire [7:0]  cnt_hi  = counter_value[15:8];
  wire [7:0]  cnt_lo  = counter_value[7:0];
  wire        hi_wrap = cnt_hi == period_limit[15:8];
  wire        lo_wrap = cnt_lo == period_limit[7:0];
  wire        top16   = counter_value >= period_limit;
  wire [7:0]  lo_next = lo_wrap ? 8'h00 : cnt_lo + 8'h01;
  wire [7:0]  hi_split = hi_wrap ? 8'h00 : cnt_hi + 8'h01;
  wire [7:0]  hi_casc = lo_wrap ? cnt_hi + 8'h01 : cnt_hi;
  wire [15:0] saw_next = top16 ? 16'h0000 : counter_value + 16'h0001;
  wire        tri_turn = !count_down && top16;
  wire        tri_zero = count_down && counter_value == 16'h0001;
  wire [15:0] tri_next =
    (count_down || tri_turn) ?
      ((counter_value == 16'h0000) ? 16'h0000
                                   : counter_value - 16'h0001) :
      counter_value + 16'h0001;
  wire [15:0] next_counter =
    (count_method == M_SAW16)  ? saw_next :
    (count_method == M_TRI16)  ? tri_next :
    (count_method == M_SPLIT8) ? {hi_split, lo_next} :
    {hi_casc, lo_next};
  wire ovf_event = step & (
    (count_method == M_SAW16)  ? top16 :
    (count_method == M_TRI16)  ? tri_zero :
    lo_wrap);
  wire next_down =
    (count_method != M_TRI16) ? 1'b0 :
    tri_turn ? 1'b1 :
    (tri_zero || counter_value == 16'h0000) ? 1'b0 : count_down;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || clear_pulse) begin
      counter_value <= 16'h0000;
      count_down    <= 1'b0;
    end else if (step) begin
      counter_value <= next_counter;
      count_down    <= next_down;
    end
  end

  // ****************************************
  // Waveform generators
  // ****************************************
  function automatic logic gen_level(input logic [2:0]  mode,
                                     input logic        pol,
                                     input logic [15:0] cnt,
                                     input logic [15:0] c1,
                                     input logic [15:0] c2,
                                     input logic [15:0] lim);
    logic raw;
    raw = 1'b0;
    case (mode)
      FULL_COMPARE_ONE: raw = cnt >= c1;
      FULL_COMPARE_TWO: raw = cnt >= c2;
      LOW_BYTE:         raw = cnt[7:0] >= c1[7:0];
      HIGH_BYTE:        raw = cnt[15:8] >= c2[7:0];
      WINDOW:           raw = cnt >= c1 && cnt <= c2;
      SQUARE_A,
      SQUARE_B:         raw = cnt > {1'b0, lim[15:1]};
      default:          raw = 1'b0;
    endcase
    return pol ? raw : ~raw;
  endfunction : gen_level

  wire lvl0 = gen_level(out0_mode_sel, out0_polarity, counter_value,
                        compare_one, compare_two, period_limit);
  wire lvl1 = gen_level(out1_mode_sel, out1_polarity, counter_value,
                        compare_one, compare_two, period_limit);

  function automatic logic [5:0] mode_flags(input logic [2:0] mode);
    logic [5:0] f;
    f = 6'h00;
    if (mode <= WINDOW) begin
      f[mode] = 1'b1;
    end
    return f;
  endfunction : mode_flags

  wire [5:0] flags = mode_flags(out0_mode_sel)
                   | mode_flags(out1_mode_sel);

  // ****************************************
  // Pin routing
  // ****************************************
  for (genvar p = 0; p < PAIRS; p++) begin : g_pair
    wire here = pin_pair_select == 3'(p);
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        pwm_pin_out[2*p]   <= 1'b0;
        pwm_pin_out[2*p+1] <= 1'b0;
        pwm_pin_oe[2*p]    <= 1'b0;
        pwm_pin_oe[2*p+1]  <= 1'b0;
      end else begin
        pwm_pin_out[2*p]   <= here & out0_pin_enable & lvl0;
        pwm_pin_out[2*p+1] <= here & out1_pin_enable & lvl1;
        pwm_pin_oe[2*p]    <= here & out0_pin_enable;
        pwm_pin_oe[2*p+1]  <= here & out1_pin_enable;
      end
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  wire accept = hsel & htrans[1] & hready;
  wire wr     = dp_active & dp_write;
  wire wr_ctrl   = wr && dp_addr == OFS_CTRL;
  wire wr_period = wr && dp_addr == OFS_PERIOD;
  wire wr_cmp    = wr && dp_addr == OFS_CMP;
  wire wr_status = wr && dp_addr == OFS_STATUS;
  wire wr_pins   = wr && dp_addr == OFS_PINS;
  // Clear bit self-returns; reserved and mask bytes read zero.
  wire [31:0] ctrl_rd = ctrl & 32'h00FF_002F;
  wire [31:0] status_rd = {29'h0, global_irq_enable, timer_irq_enable,
                           timer_overflow_flag};
  wire [31:0] rd_mux =
    (dp_addr == OFS_CTRL)   ? ctrl_rd :
    (dp_addr == OFS_COUNT)  ? {10'h000, flags, counter_value} :
    (dp_addr == OFS_PERIOD) ? {16'h0000, period_limit} :
    (dp_addr == OFS_CMP)    ? cmp :
    (dp_addr == OFS_STATUS) ? status_rd :
    (dp_addr == OFS_PINS)   ? {27'h0, pin_ctrl} :
    32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dp_active <= 1'b0;
      dp_write  <= 1'b0;
      dp_addr   <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      dp_active <= accept;
      hreadyout <= ~accept;
      if (accept) begin
        dp_write <= hwrite;
        dp_addr  <= {haddr[31:2], 2'b00};
      end
      if (dp_active && !dp_write) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl         <= RST_CTRL;
      period_limit <= RST_PERIOD;
      cmp          <= RST_CMP;
      pin_ctrl     <= 5'h00;
      clear_pulse  <= 1'b0;
    end else begin
      clear_pulse <= wr_ctrl & hwdata[POS_CLEAR];
      if (wr_ctrl) begin
        ctrl <= hwdata & 32'h00FF_002F;
      end
      if (wr_period) begin
        period_limit <= hwdata[15:0];
      end
      if (wr_cmp) begin
        cmp <= hwdata;
      end
      if (wr_pins) begin
        pin_ctrl <= hwdata[4:0];
      end
    end
  end

  // ****************************************
  // Overflow flag and interrupt request
  // ****************************************
  wire clr_flag = wr_status & hwdata[POS_OVF];
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      timer_overflow_flag <= 1'b0;
      timer_irq_enable    <= 1'b0;
      global_irq_enable   <= 1'b0;
      timer_irq           <= 1'b0;
    end else begin
      // A new overflow wins over a software clear in the same cycle.
      timer_overflow_flag <= ovf_event | (timer_overflow_flag & ~clr_flag);
      if (wr_status) begin
        timer_irq_enable  <= hwdata[POS_TIE];
        global_irq_enable <= hwdata[POS_GIE];
      end
      timer_irq <= timer_overflow_flag & timer_irq_enable
                 & global_irq_enable;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  a_split_upper_wrap: assert property (
    step && count_method == M_SPLIT8 && hi_wrap && !clear_pulse
    |=> counter_value[15:8] == 8'h00)
    else $error("Upper byte did not wrap.");
  a_split_lower_flag: assert property (
    step && count_method == M_SPLIT8 && lo_wrap
    |=> timer_overflow_flag)
    else $error("Lower byte wrap did not set flag.");
  a_split_no_flag: assert property (
    step && count_method == M_SPLIT8 && !lo_wrap
    && !timer_overflow_flag |=> !timer_overflow_flag)
    else $error("Flag set without lower wrap.");
  a_split_together: assert property (
    step && count_method == M_SPLIT8 && !hi_wrap && !lo_wrap
    && !clear_pulse |=> counter_value ==
    {$past(counter_value[15:8]) + 8'h01, $past(counter_value[7:0]) + 8'h01})
    else $error("Bytes did not step together.");
  a_cascade_carry: assert property (
    step && count_method == M_CASC8 && lo_wrap && !clear_pulse
    |=> counter_value[7:0] == 8'h00
        && counter_value[15:8] == $past(counter_value[15:8]) + 8'h01)
    else $error("Cascade carry wrong.");
  a_irq_gating: assert property (
    timer_irq |-> $past(timer_overflow_flag && timer_irq_enable
                        && global_irq_enable))
    else $error("Interrupt request without cause.");
  a_saw_wrap: assert property (
    step && count_method == M_SAW16 && top16 && !clear_pulse
    |=> counter_value == 16'h0000 && timer_overflow_flag)
    else $error("Saw counter did not wrap.");
  a_tri_zero_flag: assert property (
    step && count_method == M_TRI16 && tri_zero
    |=> counter_value == 16'h0000 ##1 timer_overflow_flag)
    else $error("Triangle zero did not set flag.");
  a_pin_route: assert property (
    out0_pin_enable |=> pwm_pin_oe[2*pin_pair_select] ||
                        $changed(pin_ctrl) || $past(wr_pins))
    else $error("Selected even pin not enabled.");
  a_mode_flag_a: assert property (
    out0_mode_sel == FULL_COMPARE_ONE |-> flags[0])
    else $error("Mode flag missing.");
  a_count_hold: assert property (
    !step && !clear_pulse |=> $stable(counter_value))
    else $error("Counter moved without a gated tick.");
  a_pins_released: assert property (
    !out0_pin_enable && !out1_pin_enable
    |=> pwm_pin_oe == '0 && pwm_pin_out == '0)
    else $error("Pin driven while both enables are off.");
  a_reserved_inverted: assert property (
    out0_mode_sel == RESERVED_MODE && !out0_polarity |-> lvl0)
    else $error("Reserved mode did not give an inverted low level.");
  a_window_low: assert property (
    out0_mode_sel == WINDOW && counter_value > compare_two
    |-> lvl0 == !out0_polarity)
    else $error("Window output not low above compare_two.");
  a_flag_cleared: assert property (
    clr_flag && !ovf_event |=> !timer_overflow_flag)
    else $error("Overflow flag not cleared by software.");
  a_overflow_sets: assert property (
    ovf_event |=> timer_overflow_flag)
    else $error("Overflow event did not set the flag.");
  a_irq_follows: assert property (
    timer_overflow_flag && timer_irq_enable && global_irq_enable
    |=> timer_irq)
    else $error("Interrupt request missing.");

  c_split_wrap:  cover property (step && count_method == M_SPLIT8 && lo_wrap);
  c_casc_carry:  cover property (step && count_method == M_CASC8 && lo_wrap);
  c_irq_raised:  cover property ($rose(timer_irq));
  c_window_high: cover property (out1_mode_sel == WINDOW && lvl1);
  c_tri_turn:    cover property (step && tri_turn);
endmodule : tmr_pwm
`default_nettype wire

// file: include/tmr_pwm_pkg.sv
// Purpose: Constants and types for the split counter and dual PWM block.
// Assumes: AHB-Lite register access with 32-bit data.
// Notes:   Offsets are byte addresses.
`default_nettype none
package tmr_pwm_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [31:0] OFS_CTRL    = 32'h0004_0C04;
  localparam logic [31:0] OFS_COUNT   = 32'h0004_0C08;
  localparam logic [31:0] OFS_PERIOD  = 32'h0004_0C0C;
  localparam logic [31:0] OFS_CMP     = 32'h0004_0C10;
  localparam logic [31:0] OFS_STATUS  = 32'h0004_0C20;
  localparam logic [31:0] OFS_PINS    = 32'h0004_0840;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          POS_TRIG    = 0;
  localparam int          POS_METHOD  = 2;
  localparam int          POS_CLEAR   = 4;
  localparam int          POS_CNT_EN  = 5;
  localparam int          POS_MODE0   = 16;
  localparam int          POS_POL0    = 19;
  localparam int          POS_MODE1   = 20;
  localparam int          POS_POL1    = 23;
  localparam int          POS_FLAGS   = 16;
  localparam int          POS_OVF     = 0;
  localparam int          POS_TIE     = 1;
  localparam int          POS_GIE     = 2;
  localparam int          POS_PEN0    = 0;
  localparam int          POS_PEN1    = 1;
  localparam int          POS_PAIR    = 2;
  localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
  localparam logic [15:0] RST_PERIOD  = 16'hFFFF;
  localparam logic [31:0] RST_CMP     = 32'hFFFF_FFFF;
  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    M_SAW16  = 2'b00,
    M_TRI16  = 2'b01,
    M_SPLIT8 = 2'b10,
    M_CASC8  = 2'b11
  } count_method_t;
  typedef enum logic [2:0] {
    FULL_COMPARE_ONE  = 3'b000,
    FULL_COMPARE_TWO  = 3'b001,
    LOW_BYTE          = 3'b010,
    HIGH_BYTE         = 3'b011,
    RESERVED_MODE     = 3'b100,
    WINDOW            = 3'b101,
    SQUARE_A          = 3'b110,
    SQUARE_B          = 3'b111
  } pwm_mode_t;
endpackage : tmr_pwm_pkg
`default_nettype wire

// file: verification/pin_load_model.sv
// Purpose: Port pins with external loads on the generator outputs.
// Assumes: Each pin has a weak pull-down on the board.
// Notes:   Pins that are not driven settle low through the pull-down.
`default_nettype none
module pin_load_model #(
  parameter int N = 16
) (
  // Pin drive from the block
  input  wire logic [N-1:0] pin_out,
  input  wire logic [N-1:0] pin_oe,
  // Levels seen by the loads
  output logic      [N-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pin reads the pull-down level, never the last driven value.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : 1'b0;
    end
  end
endmodule : pin_load_model
`default_nettype wire

// file: verification/tb_top.sv
// Purpose: Self-checking bench for the split counter and dual PWM block.
// Assumes: One wait state per bus transfer, ticks as one-cycle pulses.
// Notes:   Random setups from a fixed seed, with reset and unmapped cases.
`default_nettype none
module tb_top
  import tmr_pwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        tick_clock = 1'b0;
  logic        comparator_output = 1'b0;
  logic        amplifier_digital_output = 1'b0;
  logic        capture_input_level = 1'b0;
  logic [15:0] pwm_pin_out;
  logic [15:0] pwm_pin_oe;
  logic [15:0] pin_level;
  logic        timer_irq;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [15:0] cnt, lim, c1, c2;
  logic [1:0]  meth, trig;
  logic [2:0]  md0, md1, pair;
  logic        up, flag, p0, p1, e0, e1, en, tie, gie;
  logic [31:0] rst_a [7] = '{OFS_CTRL, OFS_COUNT, OFS_PERIOD, OFS_CMP,
                             OFS_STATUS, OFS_PINS, 32'h0004_0C30};
  logic [31:0] rst_v [7] = '{RST_CTRL, 32'h0001_0000, {16'h0, RST_PERIOD},
                             RST_CMP, 32'h0, 32'h0, 32'h0};

  always #4 ref_clk = ~ref_clk;

  tmr_pwm #(.PAIRS(8)) u_tmr_pwm (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tick_clock(tick_clock),
    .comparator_output(comparator_output),
    .amplifier_digital_output(amplifier_digital_output),
    .capture_input_level(capture_input_level),
    .pwm_pin_out(pwm_pin_out), .pwm_pin_oe(pwm_pin_oe),
    .timer_irq(timer_irq));

  pin_load_model #(.N(16)) u_pin_load_model (
    .pin_out(pwm_pin_out), .pin_oe(pwm_pin_oe), .pin_level(pin_level));

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic close_out();
    $display("errors=%0d checks=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s exp=%h seen=%h", nm, exp, seen);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : xfer

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rdc(input string nm, input logic [31:0] a, exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(nm, r, exp);
  endtask : rdc

  // ****************************************
  // Expected behaviour
  // ****************************************
  function automatic logic raw_out(input logic [2:0] m);
    case (m)
      3'h0: return cnt >= c1;
      3'h1: return cnt >= c2;
      3'h2: return cnt[7:0] >= c1[7:0];
      3'h3: return cnt[15:8] >= c2[7:0];
      3'h5: return (cnt >= c1) && (cnt <= c2);
      3'h6, 3'h7: return cnt > (lim >> 1);
      default: return 1'b0;
    endcase
  endfunction : raw_out

  function automatic logic [15:0] exp_pins(input logic oe);
    logic [15:0] v;
    v = 16'h0;
    v[{pair, 1'b0}] = e0 & (oe | (p0 ? raw_out(md0) : ~raw_out(md0)));
    v[{pair, 1'b1}] = e1 & (oe | (p1 ? raw_out(md1) : ~raw_out(md1)));
    return v;
  endfunction : exp_pins

  function automatic logic [5:0] flags();
    logic [5:0] f;
    f = 6'h0;
    if (md0 < 3'h6) f[md0] = 1'b1;
    if (md1 < 3'h6) f[md1] = 1'b1;
    return f;
  endfunction : flags

  function automatic logic [31:0] ctrl(input logic e, clr);
    return {8'h0, p1, md1, p0, md0, 10'h0, e, clr, meth, trig};
  endfunction : ctrl

  task automatic adv();
    logic [7:0] lo, hi;
    lo = cnt[7:0];
    hi = cnt[15:8];
    case (meth)
      2'h0: begin
        if (cnt >= lim) begin
          cnt = 16'h0;
          flag = 1'b1;
        end else cnt++;
      end
      2'h1: begin
        if (up && cnt >= lim) up = 1'b0;
        if (up) cnt++;
        else cnt--;
        if (!up && cnt == 16'h0) begin
          flag = 1'b1;
          up = 1'b1;
        end
      end
      default: begin
        if (meth == 2'h2) hi = (hi == lim[15:8]) ? 8'h00 : hi + 8'h01;
        if (lo == lim[7:0]) begin
          lo = 8'h00;
          flag = 1'b1;
          if (meth == 2'h3) hi = hi + 8'h01;
        end else lo = lo + 8'h01;
        cnt = {hi, lo};
      end
    endcase
  endtask : adv

  task automatic tick();
    logic [2:0] s;
    logic g;
    s = 3'($urandom);
    comparator_output <= s[0];
    amplifier_digital_output <= s[1];
    capture_input_level <= s[2];
    tick_clock <= 1'b1;
    @(posedge ref_clk);
    tick_clock <= 1'b0;
    g = (trig == 2'h0) | (trig == 2'h1 & s[0]) | (trig == 2'h2 & s[1])
        | (trig == 2'h3 & s[2]);
    if (en && g) adv();
    @(posedge ref_clk);
  endtask : tick

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      $display("[FAIL] timeout after %0d cycles", cyc);
      close_out();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hAEFE));
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk("rst oe", {16'h0, pwm_pin_oe}, 32'h0);
    wr(OFS_COUNT, 32'h0000_1234);
    wr(32'h0004_0C30, 32'hFFFF_FFFF);
    for (int i = 0; i < 7; i++) rdc("reset", rst_a[i], rst_v[i]);
    for (int it = 0; it < 32; it++) begin
      meth = it[4:3];
      md0 = it[2:0];
      md1 = 3'($urandom);
      trig = 2'($urandom);
      pair = 3'($urandom);
      {p0, p1, e0, e1, tie, gie} = 6'($urandom);
      en = (it % 7 != 6);
      lim = {meth[1] ? 8'($urandom % 3) : 8'h00, 8'(2 + $urandom % 8)};
      c1 = 16'($urandom % (lim + 16'h2));
      c2 = c1 + 16'(1 + $urandom % 4);
      wr(OFS_CMP, {c2, c1});
      wr(OFS_CTRL, ctrl(1'b0, 1'b0));
      wr(OFS_PINS, {27'h0, pair, e1, e0});
      wr(OFS_STATUS, {29'h0, gie, tie, 1'b1});
      wr(OFS_PERIOD, {16'h0, lim});
      wr(OFS_CTRL, ctrl(en, 1'b1));
      rdc("ctrl", OFS_CTRL, ctrl(en, 1'b0));
      rdc("period", OFS_PERIOD, {16'h0, lim});
      rdc("cmp", OFS_CMP, {c2, c1});
      rdc("pinsel", OFS_PINS, {27'h0, pair, e1, e0});
      cnt = 16'h0;
      up = 1'b1;
      flag = 1'b0;
      repeat (36) begin
        tick();
        rdc("count", OFS_COUNT, {10'h0, flags(), cnt});
        rdc("status", OFS_STATUS, {29'h0, gie, tie, flag});
        chk("irq", {31'h0, timer_irq}, {31'h0, flag & tie & gie});
        chk("pins", {16'h0, pin_level}, {16'h0, exp_pins(1'b0)});
        chk("oe", {16'h0, pwm_pin_oe}, {16'h0, exp_pins(1'b1)});
        if (flag) begin
          wr(OFS_STATUS, {29'h0, gie, tie, 1'b1});
          flag = 1'b0;
        end
      end
    end
    close_out();
  end
endmodule : tb_top
`default_nettype wire
